// ### core/timer8_pkg.sv
// Shared constants for the three-channel 8-bit timer/event counter block.
package timer8_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam int CHAN_COUNT = 3;
  localparam logic [7:0] CH_STRIDE = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_COMPARE = 8'h01;
  localparam logic [7:0] OFF_COUNTER = 8'h02;

  // ==========================================================
  // Mode control field positions and masks
  // ==========================================================
  localparam int RUN_BIT = 7;
  localparam int CLKSEL_HI_BIT = 2;
  localparam int CLKSEL_LO_BIT = 1;
  localparam int OUT_ENABLE_BIT = 0;
  localparam logic [7:0] MODE_MASK_PLAIN = 8'h86;
  localparam logic [7:0] MODE_MASK_WAVE = 8'h87;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [9:0] PRESCALE_RESET = 10'h000;

  // ==========================================================
  // Clock-select codes
  // ==========================================================
  localparam logic [1:0] CLK_CODE_FAST = 2'h0;
  localparam logic [1:0] CLK_CODE_SLOW = 2'h1;
  localparam logic [1:0] CLK_CODE_ALT = 2'h2;
  localparam logic [1:0] CLK_CODE_RSVD = 2'h3;

  // ==========================================================
  // Prescaler tap masks: a tap fires when all masked bits are ones
  // ==========================================================
  localparam logic [9:0] TAP_DIV8 = 10'h007;
  localparam logic [9:0] TAP_DIV16 = 10'h00F;
  localparam logic [9:0] TAP_DIV64 = 10'h03F;
  localparam logic [9:0] TAP_DIV256 = 10'h0FF;
  localparam logic [9:0] TAP_DIV512 = 10'h1FF;
  localparam logic [9:0] TAP_DIV1024 = 10'h3FF;

endpackage

// ### core/timer8_block.sv
// Three 8-bit timer/event counters with compare, event input and square wave.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
// ============================================================
// ============================================================
module timer8_block (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Asynchronous pins
  input wire logic eventInputPin,
  input wire logic subClk,
  // Match requests
  output logic ch0MatchIrq,
  output logic ch1MatchIrq,
  output logic ch2MatchIrq,
  // Square-wave pin
  output logic waveOutputPin,
  output logic waveOutEn_n
);

  // ==========================================================
  // Storage
  // ==========================================================
  logic [7:0] modeCtrl [timer8_pkg::CHAN_COUNT];
  logic [7:0] compare [timer8_pkg::CHAN_COUNT];
  logic [7:0] counter [timer8_pkg::CHAN_COUNT];
  logic [9:0] prescale;
  logic eventSync1;
  logic eventSync2;
  logic eventPrev;
  logic subSync1;
  logic subSync2;
  logic subPrev;
  logic waveLevel;
  logic [2:0] tick;
  logic [2:0] match;
  logic [7:0] next_rdData;
  logic eventRise;
  logic eventFall;
  logic subRise;

  // Address of a register of one channel.
  function automatic logic [7:0] chanAddr(input int chan, input logic [7:0] off);
    chanAddr = 8'(chan * int'(timer8_pkg::CH_STRIDE)) + off;
  endfunction

  // True when every prescaler bit under the mask is one.
  function automatic logic tapDone(input logic [9:0] pre, input logic [9:0] mask);
    tapDone = (pre & mask) == mask;
  endfunction

  // Clock-select code of one mode register.
  function automatic logic [1:0] clkCode(input logic [7:0] mode);
    clkCode = {mode[timer8_pkg::CLKSEL_HI_BIT], mode[timer8_pkg::CLKSEL_LO_BIT]};
  endfunction

  // ==========================================================
  // Input synchronisers and edge detection
  // ==========================================================
  // Two flip-flops per pin, then a third stage for edge detection.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eventSync1 <= 1'b0;
      eventSync2 <= 1'b0;
      eventPrev <= 1'b0;
      subSync1 <= 1'b0;
      subSync2 <= 1'b0;
      subPrev <= 1'b0;
    end else begin
      eventSync1 <= eventInputPin;
      eventSync2 <= eventSync1;
      eventPrev <= eventSync2;
      subSync1 <= subClk;
      subSync2 <= subSync1;
      subPrev <= subSync2;
    end
  end

  assign eventRise = eventSync2 & ~eventPrev;
  assign eventFall = ~eventSync2 & eventPrev;
  assign subRise = subSync2 & ~subPrev;

  // ==========================================================
  // Prescaler
  // ==========================================================
  // Free-running divider of the main clock; its taps feed the channels.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prescale <= timer8_pkg::PRESCALE_RESET;
    end else begin
      prescale <= prescale + 10'h001;
    end
  end

  // ==========================================================
  // Count tick selection
  // ==========================================================
  // Each channel picks one tick source from its clock-select code.
  always_comb begin
    tick = 3'h0;
    // event pin reaches channel 0 only.
    // bit 1 chooses rising or falling.
    case (clkCode(modeCtrl[0]))
      timer8_pkg::CLK_CODE_FAST: tick[0] = tapDone(prescale, timer8_pkg::TAP_DIV64);
      timer8_pkg::CLK_CODE_SLOW: tick[0] = tapDone(prescale, timer8_pkg::TAP_DIV512);
      timer8_pkg::CLK_CODE_ALT: tick[0] = eventRise;
      default: tick[0] = eventFall;
    endcase
    case (clkCode(modeCtrl[1]))
      timer8_pkg::CLK_CODE_FAST: tick[1] = tapDone(prescale, timer8_pkg::TAP_DIV16);
      timer8_pkg::CLK_CODE_SLOW: tick[1] = tapDone(prescale, timer8_pkg::TAP_DIV256);
      timer8_pkg::CLK_CODE_ALT: tick[1] = subRise;
      default: tick[1] = 1'b0;
    endcase
    case (clkCode(modeCtrl[2]))
      timer8_pkg::CLK_CODE_FAST: tick[2] = tapDone(prescale, timer8_pkg::TAP_DIV8);
      timer8_pkg::CLK_CODE_SLOW: tick[2] = tapDone(prescale, timer8_pkg::TAP_DIV1024);
      timer8_pkg::CLK_CODE_ALT: tick[2] = subRise;
      default: tick[2] = 1'b0;
    endcase
  end

  // A match is a tick of a running channel that finds the counter equal to its compare value.
  always_comb begin
    for (int c = 0; c < timer8_pkg::CHAN_COUNT; c++) begin
      match[c] = tick[c] && modeCtrl[c][timer8_pkg::RUN_BIT] && (counter[c] == compare[c]);
    end
  end

  // ==========================================================
  // Register writes
  // ==========================================================
  // Mode and compare registers; mode bits 3 to 6 are kept at zero.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int c = 0; c < timer8_pkg::CHAN_COUNT; c++) begin
        modeCtrl[c] <= timer8_pkg::MODE_RESET;
        compare[c] <= timer8_pkg::COMPARE_RESET;
      end
    end else if (regWrite) begin
      for (int c = 0; c < timer8_pkg::CHAN_COUNT; c++) begin
        if (regAddr == chanAddr(c, timer8_pkg::OFF_MODE)) begin
          // run bit lands in bit 7.
          modeCtrl[c] <= regWrData & ((c == 2) ? timer8_pkg::MODE_MASK_WAVE :
                                      timer8_pkg::MODE_MASK_PLAIN);
        end else if (regAddr == chanAddr(c, timer8_pkg::OFF_COMPARE)) begin
          compare[c] <= regWrData;
        end
      end
    end
  end

  // ==========================================================
  // Counters
  // ==========================================================
  // Counters advance on their ticks and clear on a match or on stop.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int c = 0; c < timer8_pkg::CHAN_COUNT; c++) begin
        counter[c] <= timer8_pkg::COUNTER_RESET;
      end
    end else begin
      for (int c = 0; c < timer8_pkg::CHAN_COUNT; c++) begin
        if (!modeCtrl[c][timer8_pkg::RUN_BIT]) begin
          counter[c] <= timer8_pkg::COUNTER_RESET;
        end else if (match[c]) begin
          counter[c] <= timer8_pkg::COUNTER_RESET;
        end else if (tick[c]) begin
          counter[c] <= counter[c] + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // Match requests
  // ==========================================================
  // request pulse with the clear.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ch0MatchIrq <= 1'b0;
      ch1MatchIrq <= 1'b0;
      ch2MatchIrq <= 1'b0;
    end else begin
      ch0MatchIrq <= match[0];
      ch1MatchIrq <= match[1];
      ch2MatchIrq <= match[2];
    end
  end

  // ==========================================================
  // Square wave
  // ==========================================================
  // Toggle on channel 2 match while enabled; low when stopped or disabled.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      waveLevel <= 1'b0;
    end else if (!modeCtrl[2][timer8_pkg::RUN_BIT]) begin
      waveLevel <= 1'b0;
    end else if (!modeCtrl[2][timer8_pkg::OUT_ENABLE_BIT]) begin
      waveLevel <= 1'b0;
    end else if (match[2]) begin
      waveLevel <= ~waveLevel;
    end
  end

  assign waveOutputPin = waveLevel;

  // Pin drive enable, low while the wave drives the pin.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      waveOutEn_n <= 1'b1;
    end else begin
      waveOutEn_n <= ~modeCtrl[2][timer8_pkg::OUT_ENABLE_BIT];
    end
  end

  // ==========================================================
  // Register reads
  // ==========================================================
  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    next_rdData = 8'h00;
    for (int c = 0; c < timer8_pkg::CHAN_COUNT; c++) begin
      if (regAddr == chanAddr(c, timer8_pkg::OFF_MODE)) begin
        next_rdData = modeCtrl[c];
      end else if (regAddr == chanAddr(c, timer8_pkg::OFF_COMPARE)) begin
        next_rdData = compare[c];
      end else if (regAddr == chanAddr(c, timer8_pkg::OFF_COUNTER)) begin
        next_rdData = counter[c];
      end
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= regRead ? next_rdData : 8'h00;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  for (genvar g = 0; g < timer8_pkg::CHAN_COUNT; g++) begin : gChk
    a_stop_clears_count: assert property (
      !modeCtrl[g][timer8_pkg::RUN_BIT] |=> counter[g] == timer8_pkg::COUNTER_RESET)
      else $error("Stopped counter not zero.");
    a_tick_advances_count: assert property (
      modeCtrl[g][timer8_pkg::RUN_BIT] && tick[g] && counter[g] != compare[g]
      |=> counter[g] == $past(counter[g]) + 8'h01)
      else $error("Counter did not advance on tick.");
    a_idle_holds_count: assert property (
      modeCtrl[g][timer8_pkg::RUN_BIT] && !tick[g] |=> $stable(counter[g]))
      else $error("Counter moved without tick.");
  end

  a_match_clears_ch0: assert property (
    match[0] |=> counter[0] == 8'h00 && ch0MatchIrq)
    else $error("Channel 0 match did not clear and request.");

  // The plain interval channel clears and requests on the same edge.
  a_match_clears_ch1: assert property (
    match[1] |=> counter[1] == timer8_pkg::COUNTER_RESET && ch1MatchIrq)
    else $error("Channel 1 match did not clear and request.");

  a_match_clears_ch2: assert property (
    match[2] |=> counter[2] == 8'h00 && ch2MatchIrq ##1 (!ch2MatchIrq || $past(match[2])))
    else $error("Channel 2 match did not clear and request.");

  a_reserved_no_tick: assert property (
    clkCode(modeCtrl[2]) == 2'h3 || clkCode(modeCtrl[1]) == 2'h3
    |-> !(clkCode(modeCtrl[2]) == 2'h3 && tick[2]) && !(clkCode(modeCtrl[1]) == 2'h3 && tick[1]))
    else $error("Reserved clock code produced a tick.");

  a_fast_tap_eight: assert property (
    tick[2] && clkCode(modeCtrl[2]) == 2'h0 |-> prescale[2:0] == 3'h7)
    else $error("Channel 2 fast tick not every 8 clocks.");

  a_slow_tap_1024: assert property (
    tick[2] && clkCode(modeCtrl[2]) == 2'h1 |-> prescale == 10'h3FF)
    else $error("Channel 2 slow tick not every 1024 clocks.");

  a_event_edge_select: assert property (
    modeCtrl[0][2] && tick[0] |-> (modeCtrl[0][1] ? eventFall : eventRise))
    else $error("Channel 0 counted the wrong edge.");

  a_wave_toggles: assert property (
    match[2] && modeCtrl[2][7] && modeCtrl[2][0] |=> waveOutputPin != $past(waveOutputPin))
    else $error("Wave did not toggle on match.");

  a_wave_stop_low: assert property (
    !modeCtrl[2][7] |=> !waveOutputPin)
    else $error("Wave not low while stopped.");

  a_wave_start_low: assert property (
    !modeCtrl[2][0] |=> !waveOutputPin && waveOutEn_n)
    else $error("Wave not low before output enable.");

  // The pin is driven one edge after the enable bit is set.
  a_wave_pin_driven: assert property (
    modeCtrl[2][timer8_pkg::OUT_ENABLE_BIT] |=> !waveOutEn_n)
    else $error("Wave pin not driven while enabled.");

  // Main scenarios that should each be seen at least once.
  c_event_match: cover property (match[0] && modeCtrl[0][2]);
  c_sub_match: cover property (match[1] && clkCode(modeCtrl[1]) == timer8_pkg::CLK_CODE_ALT);
  c_wave_high: cover property ($rose(waveOutputPin));
  c_reserved_run: cover property (modeCtrl[2][7] && clkCode(modeCtrl[2]) == 2'h3);
  c_back_to_back: cover property (regWrite ##1 regRead ##1 regRdData != 8'h00);

endmodule

// ### sim/timer8_partner.sv
// Far-side model: event pulse source, free subsystem clock and square-wave load.
`timescale 1ns/1ns
module timer8_partner #(
  parameter int SUB_HALF_NS = 100
) (
  // Clock
  input wire logic core_clk,
  // Pins toward the block
  output logic eventInputPin,
  output logic subClk,
  // Square-wave pin from the block
  input wire logic waveOutputPin,
  input wire logic waveOutEn_n,
  // Last measured half-period in core clocks
  output int halfPeriod
);
  logic padLevel;
  logic lastLevel = 1'h0;
  int run = 0;

  // The load pulls the pad down, so a released pin reads low.
  assign padLevel = waveOutEn_n ? 1'h0 : waveOutputPin;

  // The oscillator runs free, offset in phase from the core clock.
  initial begin
    eventInputPin = 1'h0;
    halfPeriod = 0;
    subClk = 1'h0;
    #3;
    forever #(SUB_HALF_NS) subClk = ~subClk;
  end

  always @(posedge core_clk) begin
    lastLevel <= padLevel;
    if (padLevel !== lastLevel) begin
      halfPeriod <= run;
      run <= 1;
    end else begin
      run <= run + 1;
    end
  end

  // Sends whole pulses, five cycles high and five low.
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      eventInputPin <= 1'h1;
      repeat (5) @(posedge core_clk);
      eventInputPin <= 1'h0;
      repeat (4) @(posedge core_clk);
    end
  endtask
endmodule

// ### sim/timer8_block_tb.sv
// Self-checking bench for the three-channel timer/event counter block.
`timescale 1ns/1ns
module timer8_block_tb;
  // One interval case: channel, mode with run set, compare, expected gap.
  typedef struct {
    int ch;
    logic [7:0] mode;
    logic [7:0] cmp;
    int gap;
  } row_type;
  logic core_clk, arst_n, regWrite, regRead, eventInputPin, subClk;
  logic [7:0] regAddr, regWrData, regRdData, rdVal;
  logic ch0MatchIrq, ch1MatchIrq, ch2MatchIrq, waveOutputPin, waveOutEn_n;
  logic [2:0] irqs;
  int halfPeriod;
  int g;
  int h;
  int n_errors = 0;
  int checked = 0;
  int irqCount [3] = '{0, 0, 0};
  row_type rows [9] = '{
    '{1, 8'h80, 8'h01, 32}, '{1, 8'h84, 8'h02, 60}, '{1, 8'h82, 8'h00, 256},
    '{0, 8'h80, 8'h00, 64}, '{0, 8'h82, 8'h00, 512}, '{2, 8'h81, 8'h03, 32},
    '{2, 8'h83, 8'h00, 1024}, '{2, 8'h85, 8'h01, 40}, '{2, 8'h81, 8'hFF, 2048}
  };

  // ==========================================================
  // Design and far side
  // ==========================================================
  timer8_block timer8_block_i (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .eventInputPin(eventInputPin), .subClk(subClk), .ch0MatchIrq(ch0MatchIrq),
    .ch1MatchIrq(ch1MatchIrq), .ch2MatchIrq(ch2MatchIrq), .waveOutputPin(waveOutputPin),
    .waveOutEn_n(waveOutEn_n));
  timer8_partner timer8_partner_i (.core_clk(core_clk), .eventInputPin(eventInputPin),
    .subClk(subClk), .waveOutputPin(waveOutputPin), .waveOutEn_n(waveOutEn_n),
    .halfPeriod(halfPeriod));

  assign irqs = {ch2MatchIrq, ch1MatchIrq, ch0MatchIrq};

  // Counts every match pulse of each channel.
  always @(posedge core_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (irqs[i] === 1'h1) irqCount[i] <= irqCount[i] + 1;
    end
  end

  // The clock toggles every 5 ns.
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================================
  // Bus, compare and closing tasks
  // ==========================================================
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrite <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrite <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regRead <= 1'h1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'h0;
    #1;
    d = regRdData;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for a match pulse, then counts cycles up to the next one.
  task automatic gap_of(input int ch, output int gap);
    gap = 0;
    while (irqs[ch] !== 1'h1 && gap < 3000) begin
      @(posedge core_clk);
      #1;
      gap++;
    end
    gap = 0;
    do begin
      @(posedge core_clk);
      #1;
      gap++;
    end while (irqs[ch] !== 1'h1 && gap < 3000);
  endtask

  task automatic finish_test;
    $display("Errors: %0d, comparisons: %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short well after the expected run length.
  initial begin
    #400000;
    n_errors++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrite = 1'h0;
    regRead = 1'h0;
    arst_n = 1'h0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'h1;
    #1;
    chk(waveOutEn_n, 1'h1); // pin released after reset.
    rd(8'h08, rdVal);
    chk(rdVal, timer8_pkg::MODE_RESET); // stopped after reset.
    rd(8'h01, rdVal);
    chk(rdVal, timer8_pkg::COMPARE_RESET);
    wr(8'h00, 8'h7F);
    rd(8'h00, rdVal);
    chk(rdVal, 8'h06); // only mode fields are kept.
    wr(8'h0A, 8'h55);
    rd(8'h0A, rdVal);
    chk(rdVal, timer8_pkg::COUNTER_RESET); // stopped counter stays zero.
    wr(8'h0F, 8'hFF);
    rd(8'h0F, rdVal);
    chk(rdVal, 8'h00);
    wr(8'h09, 8'hA5);
    rd(8'h09, rdVal);
    chk(rdVal, 8'hA5); // compare takes any 8-bit value.
    // Interval cases: clock and compare first, run bit last.
    foreach (rows[i]) begin
      wr(8'(4 * rows[i].ch), rows[i].mode & 8'h7F); // select clock while stopped.
      wr(8'(4 * rows[i].ch + 1), rows[i].cmp);
      if (rows[i].ch == 2) chk({waveOutEn_n, waveOutputPin}, 2'h0); // starts low.
      wr(8'(4 * rows[i].ch), rows[i].mode); // run bit starts counting.
      gap_of(rows[i].ch, g);
      chk(g, rows[i].gap); // match period.
      repeat (2) @(posedge core_clk);
      if (rows[i].ch == 2) chk(halfPeriod, rows[i].gap); // wave half-period.
      wr(8'(4 * rows[i].ch), rows[i].mode & 8'h7F);
      repeat (2) @(posedge core_clk);
      chk(waveOutputPin, 1'h0); // stop forces low.
      rd(8'(4 * rows[i].ch + 2), rdVal);
      chk(rdVal, 8'h00); // stop clears counter.
    end
    // Reserved clock code gives no ticks even with compare zero.
    wr(8'h08, 8'h07);
    wr(8'h09, 8'h00);
    wr(8'h08, 8'h87);
    wr(8'h04, 8'h06);
    wr(8'h05, 8'h00);
    wr(8'h04, 8'h86);
    g = irqCount[2];
    h = irqCount[1];
    repeat (300) @(posedge core_clk);
    chk(irqCount[2] - g, 0); // reserved code holds.
    chk(irqCount[1] - h, 0); // reserved code holds on channel 1.
    wr(8'h04, 8'h00);
    rd(8'h0A, rdVal);
    chk(rdVal, 8'h00); // counter stays zero.
    wr(8'h08, 8'h00);
    // Event counting on rising, then falling edges.
    for (int e = 0; e < 2; e++) begin
      wr(8'h00, 8'h04 | 8'(e * 2)); // edge chosen while stopped.
      wr(8'h01, 8'h02);
      wr(8'h00, 8'h84 | 8'(e * 2));
      g = irqCount[0];
      timer8_partner_i.pulses(1);
      repeat (6) @(posedge core_clk);
      rd(8'h02, rdVal);
      chk(rdVal, 8'h01); // one edge, one count.
      timer8_partner_i.pulses(5);
      repeat (6) @(posedge core_clk);
      chk(irqCount[0] - g, 2); // match every third event.
      wr(8'h00, 8'h00);
    end
    // A second reset in mid-run releases the pin and stops the channel.
    wr(8'h08, 8'h81);
    repeat (40) @(posedge core_clk);
    arst_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    chk({waveOutEn_n, waveOutputPin}, 2'h2); // reset drives wave low.
    arst_n <= 1'h1;
    rd(8'h08, rdVal);
    chk(rdVal, timer8_pkg::MODE_RESET); // run bit cleared.
    finish_test();
  end
endmodule
